// ---- hw/mdc_consts.svh ----
// Offsets, field positions, reset values and counts for the config bank
`ifndef MDC_CONSTS_SVH
`define MDC_CONSTS_SVH

// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define MDC_OFS_DUTY_STATUS 4'h6
`define MDC_OFS_FAULT_CTRL 4'h9
`define MDC_OFS_BLANK_LOW 4'hA
`define MDC_OFS_BLANK_HIGH 4'hB
`define MDC_OFS_MODE_TIMING 4'hC
`define MDC_OFS_REPORT_CFG 4'hD

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define MDC_RST_FAULT_CTRL 8'h60
`define MDC_RST_BLANK_LOW 8'h00
`define MDC_RST_BLANK_HIGH 8'h00
`define MDC_RST_MODE_TIMING 8'h63
`define MDC_RST_REPORT_CFG 8'h38

// -----------------------------------------------------------------
// Field positions in fault_and_output_control
// -----------------------------------------------------------------
`define MDC_BIT_OUT_EN 7
`define MDC_BIT_OVP_EN 6
`define MDC_BIT_STALL_EN 5
`define MDC_BIT_VOLTAGE_SENSE_FILTER_SELECT 4
`define MDC_BIT_CNT_CLR 2
`define MDC_BIT_FLT_CLR 1
`define MDC_BIT_DUTY_SEL 0
// Writable bits; bit 3 and the command bits are not stored
`define MDC_FAULT_CTRL_STORE 8'hF1
`define MDC_CMD_NUM 2
`define MDC_CMD_CNT 0
`define MDC_CMD_FLT 1

// -----------------------------------------------------------------
// Report setting field and misc constants
// -----------------------------------------------------------------
`define MDC_REP_HI 7
`define MDC_REP_LO 6
`define MDC_REP_PIN_ON_COUNT 2'b10
`define MDC_DUTY_W 6
`define MDC_BLANK_ZERO 16'h0000
`define MDC_BLANK_ONE 16'h0001
`define MDC_BYTE_ZERO 8'h00

`endif

// ---- hw/mdc_pkg.sv ----
// Types shared by the motor driver config bank
package mdc_pkg;

    // Inrush blanking sequencer, one-hot
    typedef enum logic [2:0]
    {
        MDC_IDLE = 3'b001,
        MDC_BLANK = 3'b010,
        MDC_WATCH = 3'b100
    } mdc_blank_state_t;

endpackage

// ---- hw/mdc_cmd_pulse.sv ----
// Self-clearing command bits turned into one-cycle pulses
`timescale 1ns/1ps

module mdc_cmd_pulse #(
    parameter int N = 2
) (
    clk,
    rst,
    wrHit,
    wrBits,
    pulse_q
);
    input wire logic clk;
    input wire logic rst;
    input wire logic wrHit;
    input wire logic [N-1:0] wrBits;
    output logic [N-1:0] pulse_q;

    // Each command bit acts once, then reads back as zero
    genvar i;
    generate
        for (i = 0; i < N; i = i + 1)
        begin : gCmd
            always_ff @(posedge clk)
            begin
                if (rst)
                    pulse_q[i] <= 1'b0;
                else
                    pulse_q[i] <= wrHit & wrBits[i];
            end
        end
    endgenerate
endmodule

// ---- hw/mdc_config_regs.sv ----
// Configuration and duty status registers of the motor driver
`timescale 1ns/1ps
`include "mdc_consts.svh"

// What this block does
// - Six-bit read-only internal duty status field
// - Duty code linear, zero to full scale
// - Config bank at offsets nine to thirteen
// - Output enable low keeps bridge off
// - Overvoltage enable resets high, clearable
// - Stall enable resets high, zero disables
// - Voltage sense filter select steers regulation
// - Counter clear resets counter and flag
// - Counter clear releases pin in report mode
// - Fault clear clears all latched faults
// - External duty drives bridge when selected and speed regulation is inactive
// - Low byte of inrush blanking time
// - High byte of inrush blanking time
// - Count flag latches above threshold
module mdc_config_regs (
    clk,
    rst,
    regWrEn,
    regRdEn,
    regAddr,
    regWrData,
    regRdData_q,
    internalDuty,
    hostDutyValue,
    speedRegActive,
    voltRegActive,
    rippleCountValue,
    rippleThreshold,
    faultActive,
    motorStart,
    bridgeOutEnable_q,
    bridgeDuty_q,
    overvoltageProtectEnable_q,
    stallDetectEnable_q,
    stallDetectArmed_q,
    voltageSenseFilterSelect_q,
    counterClearCommand_q,
    faultClearCommand_q,
    countReachedFlag_q,
    modeTiming_q,
    reportConfig_q,
    faultPinNOut_q,
    faultPinNOe_q
);
    input wire logic clk;
    input wire logic rst;
    input wire logic regWrEn;
    input wire logic regRdEn;
    input wire logic [3:0] regAddr;
    input wire logic [7:0] regWrData;
    output logic [7:0] regRdData_q;
    input wire logic [5:0] internalDuty;
    input wire logic [5:0] hostDutyValue;
    input wire logic speedRegActive;
    input wire logic voltRegActive;
    input wire logic [15:0] rippleCountValue;
    input wire logic [15:0] rippleThreshold;
    input wire logic faultActive;
    input wire logic motorStart;
    output logic bridgeOutEnable_q;
    output logic [5:0] bridgeDuty_q;
    output logic overvoltageProtectEnable_q;
    output logic stallDetectEnable_q;
    output logic stallDetectArmed_q;
    output logic voltageSenseFilterSelect_q;
    output logic counterClearCommand_q;
    output logic faultClearCommand_q;
    output logic countReachedFlag_q;
    output logic [7:0] modeTiming_q;
    output logic [7:0] reportConfig_q;
    output logic faultPinNOut_q;
    output logic faultPinNOe_q;

    // -----------------------------------------------------------------
    // Register storage
    // -----------------------------------------------------------------
    logic [7:0] faultCtrl_q;
    logic [7:0] blankLow_q;
    logic [7:0] blankHigh_q;
    logic [15:0] blankCnt_q;
    logic [1:0] cmdPulse;
    logic wrFaultCtrl;
    logic countPin_q;
    logic [1:0] rippleReportSetting;
    logic [15:0] inrushBlankTime;
    mdc_pkg::mdc_blank_state_t blankState_q;

    // Write decode; unlisted offsets fall through and are ignored
    assign wrFaultCtrl = regWrEn & (regAddr == `MDC_OFS_FAULT_CTRL);
    assign rippleReportSetting = reportConfig_q[`MDC_REP_HI:`MDC_REP_LO];
    assign inrushBlankTime = {blankHigh_q, blankLow_q};

    // Bank write port, reset to documented defaults
    // five byte registers at 9h..Dh
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            // overvoltage and stall enables reset high
            faultCtrl_q <= `MDC_RST_FAULT_CTRL;
            blankLow_q <= `MDC_RST_BLANK_LOW;
            blankHigh_q <= `MDC_RST_BLANK_HIGH;
            modeTiming_q <= `MDC_RST_MODE_TIMING;
            reportConfig_q <= `MDC_RST_REPORT_CFG;
        end
        else if (regWrEn)
        begin
            unique case (regAddr)
                // reserved and command bits not stored
                `MDC_OFS_FAULT_CTRL:
                    faultCtrl_q <= regWrData & `MDC_FAULT_CTRL_STORE;
                `MDC_OFS_BLANK_LOW:
                    blankLow_q <= regWrData;
                `MDC_OFS_BLANK_HIGH:
                    blankHigh_q <= regWrData;
                `MDC_OFS_MODE_TIMING:
                    modeTiming_q <= regWrData;
                `MDC_OFS_REPORT_CFG:
                    reportConfig_q <= regWrData;
                default:
                    faultCtrl_q <= faultCtrl_q;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Command pulses
    // -----------------------------------------------------------------
    mdc_cmd_pulse #(
        .N(`MDC_CMD_NUM)
    ) uCmd (
        .clk(clk),
        .rst(rst),
        .wrHit(wrFaultCtrl),
        .wrBits({regWrData[`MDC_BIT_FLT_CLR], regWrData[`MDC_BIT_CNT_CLR]}),
        .pulse_q(cmdPulse)
    );

    // Pulses retimed so outputs come straight from flops; adds one cycle
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            counterClearCommand_q <= 1'b0;
            faultClearCommand_q <= 1'b0;
        end
        else
        begin
            counterClearCommand_q <= cmdPulse[`MDC_CMD_CNT];
            faultClearCommand_q <= cmdPulse[`MDC_CMD_FLT];
        end
    end

    // -----------------------------------------------------------------
    // Count-reached flag and fault pin
    // -----------------------------------------------------------------
    // Set wins over clear so a crossing in the clear cycle is kept
    // latch when count exceeds threshold
    always_ff @(posedge clk)
    begin
        if (rst)
            countReachedFlag_q <= 1'b0;
        else if (rippleCountValue > rippleThreshold)
            countReachedFlag_q <= 1'b1;
        else if (cmdPulse[`MDC_CMD_CNT])
            countReachedFlag_q <= 1'b0;
    end

    // Pin hold for count reports; set wins over release
    // release pin only in report mode 10b
    always_ff @(posedge clk)
    begin
        if (rst)
            countPin_q <= 1'b0;
        else if ((rippleReportSetting == `MDC_REP_PIN_ON_COUNT) &&
                 (rippleCountValue > rippleThreshold))
            countPin_q <= 1'b1;
        else if (cmdPulse[`MDC_CMD_CNT] &&
                 (rippleReportSetting == `MDC_REP_PIN_ON_COUNT))
            countPin_q <= 1'b0;
    end

    // Open-drain: only ever pulls low, never drives high
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            faultPinNOut_q <= 1'b0;
            faultPinNOe_q <= 1'b0;
        end
        else
        begin
            faultPinNOut_q <= 1'b0;
            faultPinNOe_q <= faultActive | countPin_q;
        end
    end

    // -----------------------------------------------------------------
    // Bridge control outputs
    // -----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            bridgeOutEnable_q <= 1'b0;
            overvoltageProtectEnable_q <= 1'b1;
            stallDetectEnable_q <= 1'b1;
            voltageSenseFilterSelect_q <= 1'b0;
        end
        else
        begin
            // outputs off until enable bit set
            bridgeOutEnable_q <= faultCtrl_q[`MDC_BIT_OUT_EN];
            overvoltageProtectEnable_q <= faultCtrl_q[`MDC_BIT_OVP_EN];
            stallDetectEnable_q <= faultCtrl_q[`MDC_BIT_STALL_EN];
            // zero analog filter, one digital product
            voltageSenseFilterSelect_q <= faultCtrl_q[`MDC_BIT_VOLTAGE_SENSE_FILTER_SELECT];
        end
    end

    // Duty source; host duty only when unregulated and selected
    always_ff @(posedge clk)
    begin
        if (rst)
            bridgeDuty_q <= {`MDC_DUTY_W{1'b0}};
        else if (!speedRegActive && faultCtrl_q[`MDC_BIT_DUTY_SEL])
            bridgeDuty_q <= hostDutyValue;
        else
            bridgeDuty_q <= internalDuty;
    end

    // -----------------------------------------------------------------
    // Inrush blanking sequencer
    // -----------------------------------------------------------------
    // Counts clock cycles; a zero time still spends one cycle in blanking.
    // Disabling stall detection drops back to idle.
    // ignore stall during inrush window
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            blankState_q <= mdc_pkg::MDC_IDLE;
            blankCnt_q <= `MDC_BLANK_ZERO;
        end
        else if (!stallDetectEnable_q)
        begin
            blankState_q <= mdc_pkg::MDC_IDLE;
            blankCnt_q <= `MDC_BLANK_ZERO;
        end
        else if (motorStart)
        begin
            blankState_q <= mdc_pkg::MDC_BLANK;
            blankCnt_q <= inrushBlankTime;
        end
        else
        begin
            unique case (blankState_q)
                mdc_pkg::MDC_IDLE:
                    blankCnt_q <= `MDC_BLANK_ZERO;
                mdc_pkg::MDC_BLANK:
                    if (blankCnt_q == `MDC_BLANK_ZERO)
                        blankState_q <= mdc_pkg::MDC_WATCH;
                    else
                        blankCnt_q <= blankCnt_q - `MDC_BLANK_ONE;
                mdc_pkg::MDC_WATCH:
                    blankCnt_q <= `MDC_BLANK_ZERO;
            endcase
        end
    end

    // Detector armed only after the blanking window
    always_ff @(posedge clk)
    begin
        if (rst)
            stallDetectArmed_q <= 1'b0;
        else
            stallDetectArmed_q <= stallDetectEnable_q &&
                                  (blankState_q == mdc_pkg::MDC_WATCH);
    end

    // -----------------------------------------------------------------
    // Read port
    // -----------------------------------------------------------------
    // Registered read, data one cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (rst)
            regRdData_q <= `MDC_BYTE_ZERO;
        else if (regRdEn)
        begin
            unique case (regAddr)
                `MDC_OFS_DUTY_STATUS:
                    regRdData_q <= {2'b00, internalDuty};
                `MDC_OFS_FAULT_CTRL:
                    regRdData_q <= faultCtrl_q;
                `MDC_OFS_BLANK_LOW:
                    regRdData_q <= blankLow_q;
                `MDC_OFS_BLANK_HIGH:
                    regRdData_q <= blankHigh_q;
                `MDC_OFS_MODE_TIMING:
                    regRdData_q <= modeTiming_q;
                `MDC_OFS_REPORT_CFG:
                    regRdData_q <= reportConfig_q;
                default:
                    regRdData_q <= `MDC_BYTE_ZERO;
            endcase
        end
    end
endmodule

// ---- dv/mdc_config_regs_props.sv ----
// Concurrent checks on the motor driver config bank ports
`timescale 1ns/1ps
`include "mdc_consts.svh"
module mdc_config_regs_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData_q,
    input wire logic [5:0] internalDuty,
    input wire logic speedRegActive,
    input wire logic [15:0] rippleCountValue,
    input wire logic [15:0] rippleThreshold,
    input wire logic faultActive,
    input wire logic bridgeOutEnable_q,
    input wire logic [5:0] bridgeDuty_q,
    input wire logic overvoltageProtectEnable_q,
    input wire logic stallDetectEnable_q,
    input wire logic voltageSenseFilterSelect_q,
    input wire logic counterClearCommand_q,
    input wire logic faultClearCommand_q,
    input wire logic countReachedFlag_q,
    input wire logic [7:0] reportConfig_q,
    input wire logic faultPinNOut_q,
    input wire logic faultPinNOe_q
);
    logic cfgWr;
    logic cntHit;
    logic fltHit;
    logic rsvdRd;
    logic above;

    // ---------------------------------------------
    // Bus decode
    // ---------------------------------------------
    // Decoded once so every check but a_duty_read sees the same strobe view
    assign cfgWr = regWrEn && regAddr == `MDC_OFS_FAULT_CTRL;
    assign cntHit = cfgWr && regWrData[`MDC_BIT_CNT_CLR];
    assign fltHit = cfgWr && regWrData[`MDC_BIT_FLT_CLR];
    assign rsvdRd = regRdEn && regAddr != `MDC_OFS_DUTY_STATUS
        && !(regAddr inside {[4'h9:4'hD]});
    assign above = rippleCountValue > rippleThreshold;

    // ---------------------------------------------
    // Properties
    // ---------------------------------------------
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (rst);

    a_cfg_fields: assert property (
        cfgWr |-> ##2 {bridgeOutEnable_q, overvoltageProtectEnable_q,
        stallDetectEnable_q, voltageSenseFilterSelect_q}
        == $past(regWrData[7:4], 2))
        else $error("config outputs do not follow write");
    a_cnt_pulse: assert property (
        counterClearCommand_q == $past(cntHit, 2))
        else $error("counter clear pulse wrong");
    a_flt_pulse: assert property (
        faultClearCommand_q == $past(fltHit, 2))
        else $error("fault clear pulse wrong");
    a_duty_read: assert property (
        regRdEn && regAddr == `MDC_OFS_DUTY_STATUS
        |=> regRdData_q == {2'b00, $past(internalDuty)})
        else $error("duty status readback wrong");
    a_rsvd_read: assert property (
        rsvdRd |=> regRdData_q == 8'h00)
        else $error("reserved offset reads nonzero");
    a_duty_speed: assert property (
        speedRegActive |=> bridgeDuty_q == $past(internalDuty))
        else $error("regulated duty not passed to bridge");
    a_flag_set: assert property (
        above |=> countReachedFlag_q)
        else $error("count flag not set");
    a_flag_clear: assert property (
        cntHit && !above ##1 !above |=> !countReachedFlag_q)
        else $error("count flag not cleared");
    a_pin_count: assert property (
        above && reportConfig_q[`MDC_REP_HI:`MDC_REP_LO]
        == `MDC_REP_PIN_ON_COUNT |-> ##[1:3] faultPinNOe_q)
        else $error("fault pin not pulled on count");
    a_pin_fault: assert property (
        faultActive |-> ##[1:3] faultPinNOe_q)
        else $error("fault pin not pulled on fault");
    a_pin_drive: assert property (
        !faultPinNOut_q)
        else $error("open drain pin driven high");
endmodule

bind mdc_config_regs mdc_config_regs_props chk (.clk, .rst, .regWrEn,
    .regRdEn, .regAddr, .regWrData, .regRdData_q, .internalDuty,
    .speedRegActive, .rippleCountValue, .rippleThreshold, .faultActive,
    .bridgeOutEnable_q, .bridgeDuty_q, .overvoltageProtectEnable_q,
    .stallDetectEnable_q, .voltageSenseFilterSelect_q,
    .counterClearCommand_q, .faultClearCommand_q, .countReachedFlag_q,
    .reportConfig_q, .faultPinNOut_q, .faultPinNOe_q);

// ---- dv/mdc_host_model.sv ----
// Host side model issuing byte register accesses
`timescale 1ns/1ps
module mdc_host_model (
    input wire logic clk,
    output logic regWrEn,
    output logic regRdEn,
    output logic [3:0] regAddr,
    output logic [7:0] regWrData,
    input wire logic [7:0] regRdData_q
);
    // Idle bus at time zero
    initial
    begin
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 4'h0;
        regWrData = 8'h00;
    end

    task automatic write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
        regWrData <= ~d; // Stale data must not pass for valid
    endtask

    // Strobe held for one edge, data taken after it lands
    task automatic read(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        @(negedge clk);
        d = regRdData_q;
    endtask
endmodule

// ---- dv/testbench.sv ----
// Self-checking bench for the motor driver config bank
`timescale 1ns/1ps
module testbench;
    logic clk, rst, regWrEn, regRdEn, speedRegActive, voltRegActive;
    logic faultActive, motorStart, bridgeOutEnable_q, stallDetectArmed_q;
    logic overvoltageProtectEnable_q, stallDetectEnable_q;
    logic voltageSenseFilterSelect_q, counterClearCommand_q;
    logic faultClearCommand_q, countReachedFlag_q, faultPinNOe_q;
    logic [3:0] regAddr;
    logic [7:0] regWrData, regRdData_q, rd, modeTiming_q;
    logic [5:0] internalDuty, hostDutyValue, bridgeDuty_q;
    logic [15:0] rippleCountValue, rippleThreshold;
    int badCount = 0;
    int checks = 0;
    int cntPulses = 0;
    int fltPulses = 0;
    logic [7:0] rstExp [5] = '{8'h60, 8'h00, 8'h00, 8'h63, 8'h38};
    logic [5:0] dutyTab [3] = '{6'h00, 6'h3F, 6'h2A};

    mdc_host_model host (.clk, .regWrEn, .regRdEn, .regAddr, .regWrData,
        .regRdData_q);
    mdc_config_regs uut (.clk, .rst, .regWrEn, .regRdEn, .regAddr,
        .regWrData, .regRdData_q, .internalDuty, .hostDutyValue,
        .speedRegActive, .voltRegActive, .rippleCountValue,
        .rippleThreshold, .faultActive, .motorStart, .bridgeOutEnable_q,
        .bridgeDuty_q, .overvoltageProtectEnable_q, .stallDetectEnable_q,
        .stallDetectArmed_q, .voltageSenseFilterSelect_q,
        .counterClearCommand_q, .faultClearCommand_q, .countReachedFlag_q,
        .modeTiming_q, .reportConfig_q(), .faultPinNOut_q(),
        .faultPinNOe_q);

    // 200 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Count command pulses; each write of one should give exactly one
    always @(posedge clk)
    begin
        if (counterClearCommand_q === 1'b1)
            cntPulses++;
        if (faultClearCommand_q === 1'b1)
            fltPulses++;
    end

    task automatic check(input string n, input logic [7:0] e,
        input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            badCount++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic check1(input string n, input logic e, input logic g);
        check(n, {7'h00, e}, {7'h00, g});
    endtask

    task automatic rdChk(input logic [3:0] a, input logic [7:0] e);
        host.read(a, rd);
        check("readback", e, rd);
    endtask

    // Fixed wait covers the two-edge output latency
    task automatic settle;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic cfgChk(input logic [7:0] e);
        check("cfg bits", e, {bridgeOutEnable_q, overvoltageProtectEnable_q,
            stallDetectEnable_q, voltageSenseFilterSelect_q, 4'h0});
    endtask

    task automatic close_out;
        $display("Comparisons %0d mismatches %0d", checks, badCount);
        if (badCount == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        rst = 1'b1;
        speedRegActive = 1'b1;
        voltRegActive = 1'b0;
        faultActive = 1'b0;
        motorStart = 1'b0;
        internalDuty = 6'h00;
        hostDutyValue = 6'h00;
        rippleCountValue = 16'h0000;
        rippleThreshold = 16'hFFFF;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++)
            rdChk(4'h9 + 4'(i), rstExp[i]);
        cfgChk(8'h60);
        host.write(4'h9, 8'hFF);
        rdChk(4'h9, 8'hF1);
        settle();
        cfgChk(8'hF0);
        check("flt pulses", 8'h01, 8'(fltPulses));
        host.write(4'h9, 8'h04);
        host.write(4'h9, 8'h04);
        settle();
        check("cnt pulses", 8'h03, 8'(cntPulses));
        cfgChk(8'h00);
        host.write(4'hA, 8'h5A);
        host.write(4'hB, 8'hA5);
        rdChk(4'hA, 8'h5A);
        rdChk(4'hB, 8'hA5);
        host.write(4'hC, 8'h3C);
        rdChk(4'hC, 8'h3C);
        check("mode port", 8'h3C, modeTiming_q);
        host.write(4'hA, 8'h00);
        host.write(4'hB, 8'h01);
        host.write(4'h9, 8'h20);
        settle();
        @(posedge clk);
        motorStart <= 1'b1;
        @(posedge clk);
        motorStart <= 1'b0;
        repeat (240) @(posedge clk);
        @(negedge clk);
        check1("armed early", 1'b0, stallDetectArmed_q);
        repeat (30) @(posedge clk);
        @(negedge clk);
        check1("armed late", 1'b1, stallDetectArmed_q);
        // Unlisted offsets are only read; the status byte is read-only
        host.write(4'h6, 8'hFF);
        rdChk(4'h6, 8'h00);
        rdChk(4'h3, 8'h00);
        rdChk(4'hE, 8'h00);
        foreach (dutyTab[i])
        begin
            @(posedge clk);
            internalDuty <= dutyTab[i];
            rdChk(4'h6, {2'b00, dutyTab[i]});
            check("duty", {2'b00, dutyTab[i]}, {2'b00, bridgeDuty_q});
        end
        @(posedge clk);
        speedRegActive <= 1'b0;
        host.write(4'h9, 8'h01);
        // select first, then the wanted duty
        @(posedge clk);
        hostDutyValue <= 6'h15;
        settle();
        check("host duty", 8'h15, {2'b00, bridgeDuty_q});
        @(posedge clk);
        speedRegActive <= 1'b1;
        settle();
        check("reg duty", 8'h2A, {2'b00, bridgeDuty_q});
        @(posedge clk);
        rippleThreshold <= 16'h0005;
        rippleCountValue <= 16'h0100;
        host.write(4'hD, 8'h80);
        settle();
        check1("flag", 1'b1, countReachedFlag_q);
        check1("pin", 1'b1, faultPinNOe_q);
        @(posedge clk);
        rippleCountValue <= 16'h0003;
        settle();
        check1("flag held", 1'b1, countReachedFlag_q);
        host.write(4'h9, 8'h04);
        settle();
        check1("flag clr", 1'b0, countReachedFlag_q);
        check1("pin clr", 1'b0, faultPinNOe_q);
        check("cnt total", 8'h04, 8'(cntPulses));
        @(posedge clk);
        faultActive <= 1'b1;
        settle();
        check1("fault pin", 1'b1, faultPinNOe_q);
        close_out();
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        #(20000 * 5);
        badCount++;
        close_out();
    end
endmodule
